/* logic/ccrd_classify.sv */
// Cycle classification from cycle type and external decode inputs
`timescale 1ns/10ps
`default_nettype none
module ccrd_classify
  import ccrd_pkg::*;
(
  input wire logic [2:0] cyc_code_i,
  input wire logic addr_top_i,
  input wire logic noncache_access_n_i,
  input wire logic cpu_side_local_access_n_i,
  input wire logic size16_space_n_i,
  output logic local_o,
  output logic cacheable_o,
  output logic mem_read_o,
  output logic mem_write_o,
  output logic post_o
);
  // ****************************************************************
  // Decode
  // ****************************************************************
  wire coproc = (cyc_code_i[2] == 1'b0) && addr_top_i;
  wire is_local = !cpu_side_local_access_n_i || coproc;
  wire is_mem_rd = (cyc_code_i == CYC_CODE_RD) || (cyc_code_i == CYC_DATA_RD);
  wire is_mem_wr = (cyc_code_i == CYC_DATA_WR);
  wire default_nc = !is_mem_rd && !is_mem_wr;
  assign local_o = is_local;
  assign cacheable_o = !is_local && !default_nc && noncache_access_n_i && size16_space_n_i;
  assign mem_read_o = is_mem_rd;
  assign mem_write_o = is_mem_wr;
  assign post_o = !is_local && (is_mem_wr || (cyc_code_i == CYC_HALT));
endmodule
`default_nettype wire

/* logic/ccrd_cycle_ctrl.sv */
// Processor cycle qualification, response and system bus sequencing
//
// Behaviour
// - Non-cacheable cycles go to the system bus, cache and directory untouched.
// - Non-cacheable decode is sampled in the first address state.
// - Non-cacheable reads run like misses but never fill or validate.
// - Non-cacheable memory writes are latched and posted without waiting.
// - I/O, interrupt acknowledge and halt cycles are non-cacheable by default.
// - I/O reads and interrupt acknowledges complete as non-cacheable reads.
// - I/O writes hold the processor until system ready returns.
// - Halt and shutdown cycles are posted.
// - While halted the system bus still honours hold and snoops work.
// - 16-bit space is never cached; its decode is sampled in first state.
// - 16-bit cycles with enables in both halves split in halves, locked against other masters.
// - Processor-local cycles are ignored: not forwarded, no cache effect.
// - Coprocessor accesses are found from I/O select and top address bit.
// - Cycle type decodes from memory/IO, data/code and write/read selects.
// - Read hit serves from cache; miss forwards, fills and validates.
// - Cacheable writes always forward, write cache on hit, keep directory.
// - An idle system bus is released to other masters.
// - Reset or flush clears every tag valid bit.
// - Snoop hit from another master's write clears that line valid bit.
// - Fill reads assert all byte enables; others copy processor enables, with the other half masked off in each step of a split cycle.
// - In slave mode a hold request is raised and cycle runs on grant.
// - Hit result is ignored for non-cacheable or local cycles.
`timescale 1ns/10ps
`default_nettype none
module ccrd_cycle_ctrl
  import ccrd_pkg::*;
#(
  parameter int SETW = SET_W
)
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic flush_i,
  input wire logic slave_mode_i,
  input wire logic cpu_ads_n_i,
  input wire logic [ccrd_pkg::ADDR_W-1:0] cpu_addr_i,
  input wire logic [ccrd_pkg::BE_W-1:0] cpu_be_n_i,
  input wire logic cpu_mio_i,
  input wire logic cpu_dc_i,
  input wire logic cpu_wr_i,
  input wire logic [ccrd_pkg::DATA_W-1:0] cpu_data_i,
  input wire logic noncache_access_n_i,
  input wire logic cpu_side_local_access_n_i,
  input wire logic size16_space_n_i,
  output logic cpu_ready_n_o,
  output logic cache_read_o,
  output logic cache_write_o,
  output logic sys_bus_en_o,
  output logic sys_ads_n_o,
  output logic [ccrd_pkg::ADDR_W-1:0] sys_addr_o,
  output logic [ccrd_pkg::BE_W-1:0] sys_be_n_o,
  output logic sys_mio_o,
  output logic sys_dc_o,
  output logic sys_wr_o,
  output logic [ccrd_pkg::DATA_W-1:0] sys_data_o,
  output logic sys_lock_o,
  input wire logic sys_ready_n_i,
  input wire logic sysbus_hold_request_i,
  output logic sysbus_hold_request_o,
  input wire logic sysbus_hold_grant_i,
  output logic sysbus_hold_grant_o,
  input wire logic snoop_write_i,
  input wire logic [ccrd_pkg::ADDR_W-1:0] snoop_addr_i
);
  typedef enum logic [1:0] {C_IDLE, C_DECIDE, C_WAIT} ccrd_cpu_st_t;
  typedef enum logic [1:0] {S_IDLE, S_ARB, S_ADDR, S_DATA} ccrd_sys_st_t;
  ccrd_cpu_st_t cpu_q, cpu_d;
  ccrd_sys_st_t sys_q, sys_d;
  logic q_local_q, q_cache_q, q_mrd_q, q_mwr_q, q_post_q, q_hit_q, q_s16_q;
  logic [2:0] q_code_q;
  logic [ADDR_W-1:0] q_addr_q;
  logic [BE_W-1:0] q_be_q;
  logic job_fill_q, job_split_q, job_second_q, grant_q;
  logic [2:0] job_code_q;
  logic [ADDR_W-1:0] job_addr_q;
  logic [BE_W-1:0] job_be_q;
  logic [DATA_W-1:0] job_data_q;
  logic c_local, c_cache, c_mrd, c_mwr, c_post, dir_hit;
  // ****************************************************************
  // Classification and directory
  // ****************************************************************
  wire [2:0] cpu_code = {cpu_mio_i, cpu_dc_i, cpu_wr_i};
  ccrd_classify u_classify (
    .cyc_code_i(cpu_code),
    .addr_top_i(cpu_addr_i[TOP_ADDR_BIT]),
    .noncache_access_n_i(noncache_access_n_i),
    .cpu_side_local_access_n_i(cpu_side_local_access_n_i),
    .size16_space_n_i(size16_space_n_i),
    .local_o(c_local),
    .cacheable_o(c_cache),
    .mem_read_o(c_mrd),
    .mem_write_o(c_mwr),
    .post_o(c_post)
  );
  wire own = slave_mode_i ? sysbus_hold_grant_i : !grant_q;
  wire job_free = (sys_q == S_IDLE);
  wire half_last = !job_split_q || job_second_q;
  wire job_done = (sys_q == S_DATA) && !sys_ready_n_i && half_last;
  wire dir_fill = (cpu_q == C_WAIT) && job_done && job_fill_q;
  wire snoop_take = snoop_write_i && !(own && sys_q != S_IDLE) && !sys_bus_en_o;
  ccrd_directory #(.SETW(SETW), .LINEW(LINE_W)) u_directory (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .flush_i(flush_i),
    .look_addr_i(cpu_addr_i),
    .hit_o(dir_hit),
    .fill_i(dir_fill),
    .fill_addr_i(job_addr_q),
    .snoop_i(snoop_take),
    .snoop_addr_i(snoop_addr_i)
  );
  // ****************************************************************
  // Decision terms in the second processor state
  // ****************************************************************
  wire in_dec = (cpu_q == C_DECIDE);
  wire use_hit = q_cache_q && q_hit_q;
  wire rd_hit = in_dec && !q_local_q && q_mrd_q && use_hit;
  wire fwd = in_dec && !q_local_q && !rd_hit;
  wire job_load = fwd && job_free;
  wire post_now = job_load && q_post_q;
  wire fill_d = q_mrd_q && q_cache_q;
  wire split_d = q_s16_q && (q_be_q[1:0] != 2'h3) && (q_be_q[3:2] != 2'h3);
  // Local cycles are closed by outside logic, so no ready here
  assign cpu_ready_n_o = !(rd_hit || post_now || ((cpu_q == C_WAIT) && job_done));
  assign cache_read_o = rd_hit;
  assign cache_write_o = (post_now && q_mwr_q && use_hit) || dir_fill;
  // ****************************************************************
  // Processor side sequencing
  // ****************************************************************
  always_comb
  begin
    cpu_d = cpu_q;
    unique case (cpu_q)
      C_IDLE:
        if (!cpu_ads_n_i)
          cpu_d = C_DECIDE;
      C_DECIDE:
        if (q_local_q || rd_hit || post_now)
          cpu_d = C_IDLE;
        else if (job_load)
          cpu_d = C_WAIT;
      C_WAIT:
        if (job_done)
          cpu_d = C_IDLE;
    endcase
  end
  // Decodes are sampled in the first address state
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cpu_q <= C_IDLE;
      {q_local_q, q_cache_q, q_mrd_q, q_mwr_q, q_post_q, q_hit_q, q_s16_q} <= 7'h00;
      q_code_q <= CYC_INT_ACK;
      q_addr_q <= ADDR_RST;
      q_be_q <= BE_N_NONE;
    end
    else
    begin
      cpu_q <= cpu_d;
      if (cpu_q == C_IDLE && !cpu_ads_n_i)
      begin
        {q_local_q, q_cache_q, q_mrd_q, q_mwr_q, q_post_q} <= {c_local, c_cache, c_mrd, c_mwr,
          c_post};
        q_hit_q <= dir_hit;
        q_s16_q <= !size16_space_n_i;
        q_code_q <= cpu_code;
        q_addr_q <= cpu_addr_i;
        q_be_q <= cpu_be_n_i;
      end
    end
  end
  // ****************************************************************
  // System side sequencing
  // ****************************************************************
  always_comb
  begin
    sys_d = sys_q;
    unique case (sys_q)
      S_IDLE:
        if (job_load)
          sys_d = S_ARB;
      S_ARB:
        if (own)
          sys_d = S_ADDR;
      S_ADDR:
        sys_d = S_DATA;
      S_DATA:
        if (!sys_ready_n_i)
          sys_d = half_last ? S_IDLE : S_ADDR;
    endcase
  end
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sys_q <= S_IDLE;
      {job_fill_q, job_split_q, job_second_q} <= 3'h0;
      job_code_q <= CYC_INT_ACK;
      job_addr_q <= ADDR_RST;
      job_be_q <= BE_N_NONE;
      job_data_q <= DATA_RST;
    end
    else
    begin
      sys_q <= sys_d;
      if (job_load)
      begin
        job_fill_q <= fill_d;
        job_split_q <= split_d;
        job_second_q <= 1'b0;
        job_code_q <= q_code_q;
        job_addr_q <= q_addr_q;
        job_be_q <= fill_d ? BE_N_ALL : q_be_q;
        job_data_q <= cpu_data_i;
      end
      else if (sys_q == S_DATA && !sys_ready_n_i && !half_last)
        job_second_q <= 1'b1;
    end
  end
  // Master mode: grant only while the bus would otherwise sit idle
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      grant_q <= 1'b0;
    else
      grant_q <= !slave_mode_i && sysbus_hold_request_i
        && (grant_q || sys_q == S_IDLE);
  end
  // ****************************************************************
  // System bus outputs
  // ****************************************************************
  wire [BE_W-1:0] half_mask = job_second_q ? BE_N_HIGH_HALF : BE_N_LOW_HALF;
  assign sysbus_hold_grant_o = grant_q;
  assign sysbus_hold_request_o = slave_mode_i && (sys_q != S_IDLE);
  assign sys_bus_en_o = own && (sys_q == S_ADDR || sys_q == S_DATA);
  assign sys_ads_n_o = !(sys_q == S_ADDR);
  assign sys_lock_o = job_split_q && sys_bus_en_o;
  assign sys_addr_o = job_addr_q;
  assign sys_be_n_o = job_split_q ? (job_be_q | half_mask) : job_be_q;
  assign {sys_mio_o, sys_dc_o, sys_wr_o} = job_code_q;
  assign sys_data_o = job_data_q;
  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  sequence first_half_end;
    (sys_q == S_DATA) && !sys_ready_n_i && job_split_q && !job_second_q;
  endsequence
  sequence second_half_start;
    (sys_q == S_ADDR) && sys_lock_o && job_second_q;
  endsequence
  chk_fill_only_miss: assert property (dir_fill |-> job_fill_q && job_be_q == BE_N_ALL)
    else $error("directory filled by a cycle that is not a cacheable read miss");
  chk_local_ignored: assert property (in_dec && q_local_q |-> !job_load && cpu_ready_n_o
    && !cache_write_o)
    else $error("local cycle was forwarded or answered");
  chk_post_no_wait: assert property (in_dec && q_post_q && job_free |-> !cpu_ready_n_o
    ##1 sys_q == S_ARB)
    else $error("posted cycle did not end at once or was not forwarded");
  chk_io_write_held: assert property (in_dec && q_code_q == CYC_IO_WR && !q_local_q
    |-> cpu_ready_n_o)
    else $error("io write was not held");
  chk_wait_on_ready: assert property (cpu_q == C_WAIT && !cpu_ready_n_o |-> job_done
    ##1 cpu_q == C_IDLE)
    else $error("forwarded cycle answered before system ready");
  chk_fill_all_bytes: assert property (sys_q == S_ADDR && job_fill_q |-> sys_be_n_o == BE_N_ALL)
    else $error("fill read without all byte enables");
  chk_split_locked: assert property (first_half_end |=> second_half_start)
    else $error("16-bit halves not kept together");
  chk_slave_request: assert property (slave_mode_i && sys_q == S_ARB && !sysbus_hold_grant_i
    |=> sysbus_hold_request_o && sys_ads_n_o)
    else $error("slave mode ran without grant or dropped request");
  chk_grant_released: assert property (sysbus_hold_grant_o |-> !sys_bus_en_o && sys_ads_n_o)
    else $error("bus driven while granted to another master");
  chk_hit_no_bus: assert property (rd_hit && job_free |=> sys_q == S_IDLE && !sys_bus_en_o)
    else $error("read hit touched the system bus");
endmodule
`default_nettype wire

/* logic/ccrd_directory.sv */
// Tag directory with fill validation, snoop invalidation and flush
`timescale 1ns/10ps
`default_nettype none
module ccrd_directory
  import ccrd_pkg::*;
#(
  parameter int SETW = SET_W,
  parameter int LINEW = LINE_W
)
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic flush_i,
  input wire logic [ccrd_pkg::ADDR_W-1:0] look_addr_i,
  output logic hit_o,
  input wire logic fill_i,
  input wire logic [ccrd_pkg::ADDR_W-1:0] fill_addr_i,
  input wire logic snoop_i,
  input wire logic [ccrd_pkg::ADDR_W-1:0] snoop_addr_i
);
  localparam int SETS = 2 ** SETW;
  localparam int TAGW = ADDR_W - SETW - LINEW;
  if (SETW + LINEW >= ADDR_W || SETW < 1 || LINEW < 1)
  begin : g_bad
    $error("ccrd_directory: field widths do not fit the address");
  end
  logic [TAGW-1:0] tag_q [SETS];
  logic [(2**LINEW)-1:0] line_q [SETS];
  logic [SETS-1:0] tag_valid_q;
  // ****************************************************************
  // Field selection
  // ****************************************************************
  wire [SETW-1:0] l_set = look_addr_i[LINEW +: SETW];
  wire [LINEW-1:0] l_line = look_addr_i[LINEW-1:0];
  wire [TAGW-1:0] l_tag = look_addr_i[ADDR_W-1 -: TAGW];
  wire [SETW-1:0] f_set = fill_addr_i[LINEW +: SETW];
  wire [LINEW-1:0] f_line = fill_addr_i[LINEW-1:0];
  wire [TAGW-1:0] f_tag = fill_addr_i[ADDR_W-1 -: TAGW];
  wire [SETW-1:0] s_set = snoop_addr_i[LINEW +: SETW];
  wire [LINEW-1:0] s_line = snoop_addr_i[LINEW-1:0];
  wire [TAGW-1:0] s_tag = snoop_addr_i[ADDR_W-1 -: TAGW];
  wire f_tag_hit = tag_valid_q[f_set] && (tag_q[f_set] == f_tag);
  wire s_hit = tag_valid_q[s_set] && (tag_q[s_set] == s_tag) && line_q[s_set][s_line];
  wire [(2**LINEW)-1:0] f_bit = {{((2**LINEW)-1){1'b0}}, 1'b1} << f_line;
  wire [(2**LINEW)-1:0] s_bit = {{((2**LINEW)-1){1'b0}}, 1'b1} << s_line;
  assign hit_o = tag_valid_q[l_set] && (tag_q[l_set] == l_tag) && line_q[l_set][l_line];
  // ****************************************************************
  // Tag valid bits, cleared by reset or flush
  // ****************************************************************
  for (genvar g = 0; g < SETS; g++)
  begin : g_tv
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
      if (!reset_n_i)
        tag_valid_q[g] <= 1'b0;
      else if (flush_i)
        tag_valid_q[g] <= 1'b0;
      else if (fill_i && (f_set == SETW'(g)))
        tag_valid_q[g] <= 1'b1;
    end
  end
  // ****************************************************************
  // Tags and line valid bits; snoop clear wins on the same line
  // ****************************************************************
  always_ff @(posedge core_clk_i)
  begin
    if (fill_i)
    begin
      tag_q[f_set] <= f_tag;
      line_q[f_set] <= f_tag_hit ? (line_q[f_set] | f_bit) : f_bit;
    end
    if (snoop_i && s_hit)
      line_q[s_set] <= ((fill_i && f_set == s_set) ? (f_tag_hit ? (line_q[s_set] | f_bit)
        : f_bit) : line_q[s_set]) & ~s_bit;
  end
endmodule
`default_nettype wire

/* shared/ccrd_pkg.sv */
// Shared constants for the processor cycle response decoder
package ccrd_pkg;
  // ****************************************************************
  // Bus widths
  // ****************************************************************
  localparam int ADDR_W = 30;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int TOP_ADDR_BIT = 29;
  // ****************************************************************
  // Directory field layout (line, set, tag from the word address)
  // ****************************************************************
  localparam int LINE_W = 3;
  localparam int SET_W = 10;
  localparam int LINE_LSB = 0;
  localparam int SET_LSB = 3;
  localparam int TAG_LSB = 13;
  // ****************************************************************
  // Cycle codes {mem_io, data_code, write_read}
  // ****************************************************************
  localparam logic [2:0] CYC_INT_ACK = 3'h0;
  localparam logic [2:0] CYC_UNDEF = 3'h1;
  localparam logic [2:0] CYC_IO_RD = 3'h2;
  localparam logic [2:0] CYC_IO_WR = 3'h3;
  localparam logic [2:0] CYC_CODE_RD = 3'h4;
  localparam logic [2:0] CYC_HALT = 3'h5;
  localparam logic [2:0] CYC_DATA_RD = 3'h6;
  localparam logic [2:0] CYC_DATA_WR = 3'h7;
  // ****************************************************************
  // Byte enable patterns and reset values
  // ****************************************************************
  localparam logic [3:0] BE_N_ALL = 4'h0;
  localparam logic [3:0] BE_N_NONE = 4'hF;
  localparam logic [3:0] BE_N_LOW_HALF = 4'hC;
  localparam logic [3:0] BE_N_HIGH_HALF = 4'h3;
  localparam logic [29:0] ADDR_RST = 30'h0000_0000;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
endpackage

/* sim/ccrd_cycle_ctrl_tb.sv */
// Self-checking bench for the processor cycle response decoder
`timescale 1ns/10ps
`default_nettype none
module ccrd_cycle_ctrl_tb;
  import ccrd_pkg::*;
  logic clk, rst_n, flush, ads_n, mio, dc, wr, nca_n, lba_n, s16_n, hreq, snp;
  logic rdy_n, crd, cwr, ben, sads_n, smio, sdc, swr, lock, srdy_n, hreq_o, hgnt_i, hgnt_o;
  logic [ADDR_W-1:0] addr, snp_addr, sa, a_seen;
  logic [2:0] code_seen;
  logic [BE_W-1:0] be_n, sbe;
  logic [DATA_W-1:0] wdata, sd, d_seen;
  logic [3:0] wt, be_seen;
  logic c_rd, c_wr, lk, hq, slave;
  int fails, check_count, rdy_at, n_ads;
  ccrd_cycle_ctrl i_ccrd_cycle_ctrl (.core_clk_i(clk), .reset_n_i(rst_n), .flush_i(flush),
    .slave_mode_i(slave), .cpu_ads_n_i(ads_n), .cpu_addr_i(addr), .cpu_be_n_i(be_n),
    .cpu_mio_i(mio), .cpu_dc_i(dc), .cpu_wr_i(wr), .cpu_data_i(wdata),
    .noncache_access_n_i(nca_n), .cpu_side_local_access_n_i(lba_n),
    .size16_space_n_i(s16_n), .cpu_ready_n_o(rdy_n), .cache_read_o(crd),
    .cache_write_o(cwr), .sys_bus_en_o(ben), .sys_ads_n_o(sads_n), .sys_addr_o(sa),
    .sys_be_n_o(sbe), .sys_mio_o(smio), .sys_dc_o(sdc), .sys_wr_o(swr), .sys_data_o(sd),
    .sys_lock_o(lock), .sys_ready_n_i(srdy_n), .sysbus_hold_request_i(hreq),
    .sysbus_hold_request_o(hreq_o), .sysbus_hold_grant_i(hgnt_i),
    .sysbus_hold_grant_o(hgnt_o), .snoop_write_i(snp), .snoop_addr_i(snp_addr));
  ccrd_sys_model i_ccrd_sys_model (.core_clk_i(clk), .reset_n_i(rst_n),
    .sys_ads_n_i(sads_n), .hold_req_i(hreq_o), .wait_i(wt), .sys_ready_n_o(srdy_n),
    .hold_grant_o(hgnt_i));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ********************
  // Shared tasks
  // ********************
  task automatic finish_test;
    if (fails == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (exp !== got)
    begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic cpu_cycle(input logic [2:0] code, input logic [ADDR_W-1:0] a,
    input logic [3:0] b, input logic nca, input logic lba, input logic s16);
    rdy_at = 0;
    n_ads = 0;
    {c_rd, c_wr, lk, hq, be_seen, d_seen, a_seen, code_seen} = '0;
    {mio, dc, wr} = code;
    {addr, be_n, nca_n, lba_n, s16_n} = {a, b, nca, lba, s16};
    ads_n = 1'b0;
    @(posedge clk);
    #1 ads_n = 1'b1;
    for (int i = 1; i < 25; i++)
    begin
      @(negedge clk);
      if (rdy_at == 0 && rdy_n === 1'b0)
        rdy_at = i;
      c_rd |= (crd === 1'b1);
      c_wr |= (cwr === 1'b1);
      lk |= (lock === 1'b1);
      hq |= (hreq_o === 1'b1);
      if (sads_n === 1'b0)
      begin
        if (n_ads == 0)
          {be_seen, d_seen, a_seen, code_seen} = {sbe, sd, sa, smio, sdc, swr};
        n_ads++;
      end
      @(posedge clk);
      #1;
    end
  endtask
  // ********************
  // Scenarios
  // ********************
  task automatic t_miss_hit;
    cpu_cycle(CYC_DATA_RD, 30'h0000_0123, 4'hE, 1'b1, 1'b1, 1'b1);
    check("miss sys ads", 1, n_ads);
    check("miss be", BE_N_ALL, be_seen);
    check("miss addr", 30'h0000_0123, a_seen);
    check("miss no request", 0, hq);
    check("miss fill", 1, c_wr);
    check("miss late ready", 1, rdy_at > 1);
    cpu_cycle(CYC_CODE_RD, 30'h0000_0123, 4'hE, 1'b1, 1'b1, 1'b1);
    check("hit sys ads", 0, n_ads);
    check("hit ready", 1, rdy_at);
    check("hit cache read", 1, c_rd);
  endtask
  task automatic t_noncache;
    cpu_cycle(CYC_DATA_RD, 30'h0000_0456, 4'h3, 1'b0, 1'b1, 1'b1);
    check("nc rd ads", 1, n_ads);
    check("nc rd be", 4'h3, be_seen);
    check("nc rd fill", 0, c_wr);
    cpu_cycle(CYC_DATA_RD, 30'h0000_0456, 4'h3, 1'b1, 1'b1, 1'b1);
    check("nc not valid", 1, n_ads);
    cpu_cycle(CYC_DATA_RD, 30'h0000_0789, 4'h0, 1'b1, 1'b1, 1'b0);
    check("s16 halves", 2, n_ads);
    check("s16 low half", BE_N_LOW_HALF, be_seen);
    check("s16 lock", 1, lk);
    check("s16 fill", 0, c_wr);
    cpu_cycle(CYC_DATA_RD, 30'h0000_0789, 4'h0, 1'b1, 1'b1, 1'b1);
    check("s16 not valid", 1, n_ads);
  endtask
  task automatic t_posting;
    cpu_cycle(CYC_DATA_WR, 30'h0000_00AB, 4'h0, 1'b0, 1'b1, 1'b1);
    check("nc wr ready", 1, rdy_at);
    check("nc wr data", 32'h1234_5678, d_seen);
    check("nc wr type", CYC_DATA_WR, code_seen);
    check("nc wr cache", 0, c_wr);
    cpu_cycle(CYC_DATA_WR, 30'h0000_0123, 4'h0, 1'b1, 1'b1, 1'b1);
    check("wr hit cache", 1, c_wr);
    check("wr hit fwd", 1, n_ads);
    cpu_cycle(CYC_DATA_WR, 30'h0000_0321, 4'h0, 1'b1, 1'b1, 1'b1);
    check("wr miss cache", 0, c_wr);
    cpu_cycle(CYC_DATA_RD, 30'h0000_0321, 4'h0, 1'b1, 1'b1, 1'b1);
    check("wr no validate", 1, n_ads);
  endtask
  task automatic t_default_nc;
    logic [2:0] codes [5] = '{CYC_INT_ACK, CYC_UNDEF, CYC_IO_RD, CYC_IO_WR, CYC_HALT};
    for (int k = 0; k < 5; k++)
    begin
      cpu_cycle(codes[k], 30'h0000_0123, 4'hE, 1'b1, 1'b1, 1'b1);
      check("dflt fwd", 1, n_ads);
      check("dflt type", codes[k], code_seen);
      check("dflt no cache", 0, c_rd | c_wr);
      check("dflt posted", codes[k] == CYC_HALT, rdy_at == 1);
    end
  endtask
  task automatic t_local;
    cpu_cycle(CYC_DATA_RD, 30'h0000_0123, 4'hE, 1'b1, 1'b0, 1'b1);
    check("local ads", 0, n_ads);
    check("local quiet", 0, c_rd | (rdy_at != 0));
    cpu_cycle(CYC_IO_RD, 30'h2000_0000, 4'hE, 1'b1, 1'b1, 1'b1);
    check("copro ads", 0, n_ads);
  endtask
  task automatic t_snoop_flush;
    int n;
    cpu_cycle(CYC_HALT, 30'h0000_0000, 4'hE, 1'b1, 1'b1, 1'b1);
    hreq = 1'b1;
    n = 0;
    while (hgnt_o !== 1'b1 && n < 8)
    begin
      @(posedge clk);
      #1 n++;
    end
    check("hold grant", 1, hgnt_o);
    if (n == 8)
      finish_test();
    check("bus released", 0, ben);
    {snp_addr, snp} = {30'h0000_0123, 1'b1};
    @(posedge clk);
    #1 {snp, hreq} = 2'b00;
    @(posedge clk);
    #1;
    cpu_cycle(CYC_DATA_RD, 30'h0000_0123, 4'hE, 1'b1, 1'b1, 1'b1);
    check("snoop cleared", 1, n_ads);
    cpu_cycle(CYC_DATA_RD, 30'h0000_0456, 4'hE, 1'b1, 1'b1, 1'b1);
    check("snoop other kept", 0, n_ads);
    flush = 1'b1;
    @(posedge clk);
    #1 flush = 1'b0;
    cpu_cycle(CYC_DATA_RD, 30'h0000_0456, 4'hE, 1'b1, 1'b1, 1'b1);
    check("flush cleared", 1, n_ads);
    rst_n = 1'b0;
    @(posedge clk);
    #1 rst_n = 1'b1;
    @(posedge clk);
    #1;
    cpu_cycle(CYC_DATA_RD, 30'h0000_0456, 4'hE, 1'b1, 1'b1, 1'b1);
    check("reset cleared", 1, n_ads);
  endtask
  task automatic t_slave;
    slave = 1'b1;
    cpu_cycle(CYC_DATA_WR, 30'h0000_0555, 4'h0, 1'b0, 1'b1, 1'b1);
    check("slave request", 1, hq);
    check("slave fwd", 1, n_ads);
    check("slave posted", 1, rdy_at);
    check("slave request off", 0, hreq_o);
  endtask
  initial
  begin
    {fails, check_count} = '0;
    {rst_n, flush, mio, dc, wr, hreq, snp, slave} = '0;
    {ads_n, nca_n, lba_n, s16_n} = 4'hF;
    {addr, snp_addr, be_n, wdata, wt} = {30'h0, 30'h0, 4'hF, 32'h1234_5678, 4'h2};
    repeat (10) @(posedge clk);
    check("reset ready", 1, rdy_n);
    check("reset grant", 0, hgnt_o);
    #1 rst_n = 1'b1;
    @(posedge clk);
    #1;
    t_miss_hit();
    t_noncache();
    t_posting();
    t_default_nc();
    t_local();
    t_snoop_flush();
    t_slave();
    finish_test();
  end
endmodule
`default_nettype wire

/* sim/ccrd_sys_model.sv */
// System bus partner model: ready responder and hold grant
`timescale 1ns/10ps
`default_nettype none
module ccrd_sys_model
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic sys_ads_n_i,
  input wire logic hold_req_i,
  input wire logic [3:0] wait_i,
  output logic sys_ready_n_o,
  output logic hold_grant_o
);
  logic [4:0] cnt_q;
  // ********************
  // Ready after the chosen wait states, pulled high otherwise
  // ********************
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sys_ready_n_o <= 1'b1;
      cnt_q <= 5'h1F;
      hold_grant_o <= 1'b0;
    end
    else
    begin
      sys_ready_n_o <= 1'b1;
      hold_grant_o <= hold_req_i;
      if (!sys_ads_n_i)
        cnt_q <= {1'b0, wait_i};
      else if (cnt_q == 5'h00)
      begin
        sys_ready_n_o <= 1'b0;
        cnt_q <= 5'h1F;
      end
      else if (cnt_q != 5'h1F)
        cnt_q <= cnt_q - 5'h01;
    end
  end
endmodule
`default_nettype wire
